// ---- hw/tacs_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "tacs_defines.svh"

module tacs_regs #(
    parameter int NUM_CH = `TACS_NUM_CH  // Channel count
) (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 srst_i,
    // Protocol engine side
    input  wire tacs_pkg::tacs_host_t host_i,
    output logic [7:0]                reg_index_o,
    output logic [7:0]                rd_data_o,
    output logic                      timeout_en_o,
    output logic                      ara_pending_o,
    // Measurement engine side
    input  wire tacs_pkg::tacs_conv_t conv_i,
    output logic                      standby_o,
    output logic                      wide_range_o,
    output logic                      soft_reset_o,
    output tacs_pkg::tacs_result_t    result_o,
    // Open-drain alarm pins, enable high while pulling low
    output logic                      warn_irq_n_o,
    output logic                      warn_irq_n_oe_o,
    output logic                      overtemp_out_n_o,
    output logic                      overtemp_out_n_oe_o
);

    // Bit layout is fixed to eight channels
    if (NUM_CH != 8) begin : g_bad_ch
        $error("tacs_regs supports exactly eight channels");
    end

    // Register state
    logic [7:0] reg_index;    // Index pointer
    logic [7:0] config_q;     // Stored configuration bits
    logic [7:0] warn_mask;    // Warn output mask
    logic [7:0] ot_mask;      // Overtemp output mask
    logic [7:0] high_stat;    // High warn status
    logic [7:0] low_stat;     // Low warn status
    logic [7:0] ot_stat;      // Overtemp status
    logic [7:0] fault_stat;   // Diode fault status
    logic       warn_latch;   // Warn output latch
    logic       ot_drive;     // Overtemp pin pulled low
    logic       pin_level;    // Level driven onto both pins

    // Decoded events
    logic       soft_rst;     // Soft reset request this cycle
    logic       any_rst;      // Hardware or soft reset
    logic       cfg_wr;       // Configuration write
    logic       conv_ok;      // Conversion accepted
    logic       rd_high;      // High status read done
    logic       rd_low;       // Low status read done
    logic [7:0] code;         // Encoded temperature
    logic [7:0] hw_bit;       // One-hot in warn layout
    logic [7:0] ot_bit;       // One-hot in overtemp layout
    logic [7:0] high_set;     // High bits set now
    logic [7:0] low_set;      // Low bits set now
    logic [7:0] next_high;    // Next high status
    logic [7:0] next_low;     // Next low status

    // Warn layout: 7 remote 7, 6 local, 5..0 remote 6..1
    function automatic logic [7:0] warn_onehot(input logic [2:0] ch);
        logic [7:0] v;
        v = 8'h00;
        if (ch == 3'h0) begin
            v[6] = 1'b1;
        end else if (ch == 3'h7) begin
            v[7] = 1'b1;
        end else begin
            v[ch - 3'h1] = 1'b1;
        end
        return v;
    endfunction : warn_onehot

    // Overtemp layout: 7 local, 6..0 remote 7..1
    function automatic logic [7:0] ot_onehot(input logic [2:0] ch);
        logic [7:0] v;
        v = 8'h00;
        if (ch == 3'h0) begin
            v[7] = 1'b1;
        end else begin
            v[ch - 3'h1] = 1'b1;
        end
        return v;
    endfunction : ot_onehot

    // Clamp a temperature into the eight-bit code of the active range
    function automatic logic [7:0] encode(input logic signed [9:0] t,
                                          input logic wide);
        logic signed [9:0] s;
        s = wide ? (t + `TACS_WIDE_OFFSET) : t;
        if (s < 10'sd0) begin
            return 8'h00;
        end else if (s > `TACS_CODE_MAX) begin
            return 8'hff;
        end
        return s[7:0];
    endfunction : encode

    // Event decode
    always_comb begin
        cfg_wr   = host_i.reg_wr && (reg_index == `TACS_OFS_CONFIG);
        soft_rst = cfg_wr && host_i.data[`TACS_CFG_SOFT_RESET];
        any_rst  = srst_i || soft_rst;
        conv_ok  = conv_i.valid && !config_q[`TACS_CFG_STANDBY];
        rd_high  = host_i.rd_done && (reg_index == `TACS_OFS_HIGH_STAT);
        rd_low   = host_i.rd_done && (reg_index == `TACS_OFS_LOW_STAT);
        code     = encode(conv_i.temp, config_q[`TACS_CFG_WIDE_RANGE]);
        hw_bit   = warn_onehot(conv_i.chan);
        ot_bit   = ot_onehot(conv_i.chan);
    end

    // Index pointer; soft reset returns it to zero too
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            reg_index <= `TACS_RST_INDEX;
        end else if (host_i.index_wr) begin
            reg_index <= host_i.data;
        end
    end

    // Configuration; soft reset bit is never stored so it reads back 0
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            config_q <= `TACS_RST_CONFIG;
        end else if (cfg_wr) begin
            // Unused bits dropped in case the host breaks its promise
            config_q <= host_i.data & `TACS_CFG_WR_MASK;
        end
    end

    // Mask registers
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            warn_mask <= `TACS_RST_MASK;
            ot_mask   <= `TACS_RST_MASK;
        end else if (host_i.reg_wr) begin
            if (reg_index == `TACS_OFS_WARN_MASK) begin
                warn_mask <= host_i.data;
            end
            if (reg_index == `TACS_OFS_OT_MASK) begin
                ot_mask <= host_i.data;
            end
        end
    end

    // New high and low flags; masks play no part here
    always_comb begin
        high_set = 8'h00;
        low_set  = 8'h00;
        if (conv_ok && !conv_i.fault) begin
            if (code > conv_i.high_lim) begin
                high_set = hw_bit;
            end
            if (code < conv_i.low_lim) begin
                low_set = hw_bit;
            end
        end
        // A flag raised in the cycle of its read survives the clear
        next_high = (rd_high ? 8'h00 : high_stat) | high_set;
        next_low  = (rd_low ? 8'h00 : low_stat) | low_set;
    end

    // Warn status registers, cleared by reading them
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            high_stat <= `TACS_RST_STAT;
            low_stat  <= `TACS_RST_STAT;
        end else begin
            high_stat <= next_high;
            low_stat  <= next_low;
        end
    end

    // Overtemp status holds until the reading drops four degrees under
    // the limit; a raised limit is seen at the channel's next conversion
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            ot_stat <= `TACS_RST_STAT;
        end else if (conv_ok && !conv_i.fault) begin
            if (code > conv_i.ot_lim) begin
                ot_stat <= ot_stat | ot_bit;
            end else if ({1'b0, code} + `TACS_OT_HYST <= {1'b0, conv_i.ot_lim}) begin
                ot_stat <= ot_stat & ~ot_bit;
            end
        end
    end

    // Diode fault status follows the latest conversion of each remote channel
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            fault_stat <= `TACS_RST_STAT;
        end else if (conv_ok && (conv_i.chan != 3'h0)) begin
            if (conv_i.fault) begin
                fault_stat <= fault_stat | ot_bit;
            end else begin
                fault_stat <= fault_stat & ~ot_bit;
            end
        end
    end

    // Result to the temperature store; a faulty diode reads all ones
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            result_o <= '0;
        end else begin
            result_o.wr   <= conv_ok;
            result_o.chan <= conv_i.chan;
            result_o.code <= conv_i.fault ? `TACS_FAULT_CODE : code;
        end
    end

    // Warn latch: raised at conversion end by an unmasked flag, dropped
    // by a high or low status read or alert response even if the fault persists.
    // Masking all pending flags also drops it, so no masked flag holds the pin.
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            warn_latch <= 1'b0;
        end else if (|((high_set | low_set) & ~warn_mask)) begin
            warn_latch <= 1'b1;
        end else if (rd_high || rd_low || host_i.ara_done) begin
            warn_latch <= 1'b0;
        end else if (!(|((high_stat | low_stat) & ~warn_mask))) begin
            warn_latch <= 1'b0;
        end
    end

    // Overtemp pin tracks unmasked overtemp flags one cycle later
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            ot_drive <= 1'b0;
        end else begin
            ot_drive <= |(ot_stat & ~ot_mask);
        end
    end

    // Pins only ever pull low; the level flop keeps outputs registered
    always_ff @(posedge clk_i) begin
        pin_level <= 1'b0;
    end

    // Read data mirrors the indexed register, unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            rd_data_o <= 8'h00;
        end else begin
            case (reg_index)
                `TACS_OFS_CONFIG:     rd_data_o <= config_q;
                `TACS_OFS_WARN_MASK:  rd_data_o <= warn_mask;
                `TACS_OFS_OT_MASK:    rd_data_o <= ot_mask;
                `TACS_OFS_HIGH_STAT:  rd_data_o <= high_stat;
                `TACS_OFS_OT_STAT:    rd_data_o <= ot_stat;
                `TACS_OFS_FAULT_STAT: rd_data_o <= fault_stat;
                `TACS_OFS_LOW_STAT:   rd_data_o <= low_stat;
                default:              rd_data_o <= 8'h00;
            endcase
        end
    end

    // Control outputs, registered copies of configuration state and of the soft reset write
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            standby_o    <= 1'b0;
            wide_range_o <= 1'b0;
            timeout_en_o <= 1'b1;
            soft_reset_o <= 1'b0;
        end else begin
            standby_o    <= config_q[`TACS_CFG_STANDBY];
            wide_range_o <= config_q[`TACS_CFG_WIDE_RANGE];
            timeout_en_o <= !config_q[`TACS_CFG_TMO_DIS];
            soft_reset_o <= soft_rst;
        end
    end

    // Pin and status outputs
    assign reg_index_o         = reg_index;
    assign ara_pending_o       = warn_latch;
    assign warn_irq_n_o        = pin_level;
    assign warn_irq_n_oe_o     = warn_latch;
    assign overtemp_out_n_o    = pin_level;
    assign overtemp_out_n_oe_o = ot_drive;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    index_reset_a: assert property (
        $past(soft_rst) |-> reg_index == 8'h00)
        else $error("index not cleared by soft reset");

    standby_block_a: assert property (
        (config_q[7] && conv_i.valid) |=> !result_o.wr)
        else $error("conversion accepted in standby");

    soft_clear_a: assert property (
        soft_rst |=> config_q == 8'h00 && warn_mask == 8'h00 && soft_reset_o)
        else $error("soft reset did not restore registers");

    timeout_ctl_a: assert property (
        $stable(config_q) [*2] |-> timeout_en_o == !config_q[5])
        else $error("timeout enable wrong");

    reserved_zero_a: assert property (
        (config_q & 8'h5d) == 8'h00)
        else $error("reserved configuration bit stored");

    wide_code_a: assert property (
        (conv_ok && !conv_i.fault && config_q[1] && conv_i.temp == -10'sd64)
        |=> result_o.code == 8'h00)
        else $error("wide range code wrong");

    high_set_a: assert property (
        (conv_ok && !conv_i.fault && !soft_rst && conv_i.chan == 3'h0
         && code > conv_i.high_lim) |=> high_stat[6])
        else $error("local high flag not set");

    read_clear_a: assert property (
        (rd_high && !(|high_set)) |=> high_stat == 8'h00)
        else $error("high status not cleared by read");

    warn_drop_a: assert property (
        (host_i.ara_done && !(|(high_set | low_set))) |=> !warn_irq_n_oe_o)
        else $error("warn not released by alert response");

    ot_hold_a: assert property (
        (conv_ok && !conv_i.fault && !soft_rst && |(ot_stat & ot_bit)
         && {1'b0, code} <= {1'b0, conv_i.ot_lim}
         && {1'b0, code} + 9'h004 > {1'b0, conv_i.ot_lim})
        |=> |(ot_stat & $past(ot_bit)))
        else $error("overtemp cleared inside hysteresis");

    fault_store_a: assert property (
        (conv_ok && conv_i.fault && !soft_rst) |=> result_o.code == 8'hff
        && $stable(ot_stat))
        else $error("fault code not all ones");

    ot_pin_a: assert property (
        |(ot_stat & ~ot_mask) [*2] |-> overtemp_out_n_oe_o)
        else $error("overtemp pin not driven");

endmodule : tacs_regs
`default_nettype wire

// ---- hw/tacs_defines.svh ----
// Functional notes
// - Eight-bit register index, zero after reset
// - Standby bit halts conversions when set
// - Soft reset restores registers, bit self-clears
// - Bus timeout applied only while bit is 0
// - Wide range encodes -64..191, else 0..255
// - Warn mask bit layout gates warn output
// - Overtemp mask bit layout gates overtemp output
// - High status bit set above high limit
// - Reading alert status clears, conversion sets again
// - Warn output cleared by read or response
// - Pending warning answers alert response query
// - Overtemp bit clears at or below limit minus four
// - Overtemp status flags temperature above limit
// - Diode fault status flags open or short
// - Low status flags temperature below low limit
// - Diode fault stores all ones, no alarm
`ifndef TACS_DEFINES_SVH
`define TACS_DEFINES_SVH

// Register offsets
`define TACS_OFS_CONFIG      8'h41
`define TACS_OFS_WARN_MASK   8'h42
`define TACS_OFS_OT_MASK     8'h43
`define TACS_OFS_HIGH_STAT   8'h44
`define TACS_OFS_OT_STAT     8'h45
`define TACS_OFS_FAULT_STAT  8'h46
`define TACS_OFS_LOW_STAT    8'h47

// Reset values
`define TACS_RST_INDEX       8'h00
`define TACS_RST_CONFIG      8'h00
`define TACS_RST_MASK        8'h00
`define TACS_RST_STAT        8'h00

// Configuration field positions
`define TACS_CFG_STANDBY     7
`define TACS_CFG_SOFT_RESET  6
`define TACS_CFG_TMO_DIS     5
`define TACS_CFG_WIDE_RANGE  1
`define TACS_CFG_WR_MASK     8'ha2

// Encoding and hysteresis
`define TACS_WIDE_OFFSET     10'sd64
`define TACS_CODE_MAX        10'sd255
`define TACS_OT_HYST         9'h004
`define TACS_FAULT_CODE      8'hff

// Channel numbering: 0 local, 1..7 remote
`define TACS_NUM_CH          8

`endif

// ---- hw/tacs_pkg.sv ----
package tacs_pkg;

    // One finished conversion from the measurement engine
    typedef struct packed {
        logic              valid;     // One-cycle pulse
        logic [2:0]        chan;      // 0 local, 1..7 remote
        logic signed [9:0] temp;      // Whole degrees C
        logic              fault;     // Open or shorted diode
        logic [7:0]        high_lim;  // Encoded high warn limit
        logic [7:0]        low_lim;   // Encoded low warn limit
        logic [7:0]        ot_lim;    // Encoded overtemp limit
    } tacs_conv_t;

    // Register access decoded by the serial protocol engine
    typedef struct packed {
        logic       index_wr;  // Pulse: data is a new index
        logic       reg_wr;    // Pulse: data goes to indexed register
        logic       rd_done;   // Pulse: indexed read acknowledged
        logic       ara_done;  // Pulse: alert response completed
        logic [7:0] data;      // Write data
    } tacs_host_t;

    // Result handed back to the temperature store
    typedef struct packed {
        logic       wr;    // Pulse: store code for chan
        logic [2:0] chan;
        logic [7:0] code;  // Encoded temperature
    } tacs_result_t;

endpackage : tacs_pkg

// ---- test/tacs_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module tacs_host_model (
    // Clock and readback
    input  wire logic           clk_i,
    input  wire logic [7:0]     rd_data_i,
    // Decoded host requests
    output tacs_pkg::tacs_host_t host_o
);

    // Idle bus at time zero
    initial begin
        host_o = '0;
    end

    // One request pulse; released data is inverted so it never looks valid
    task automatic pulse(input logic [3:0] kind, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        host_o = {kind, d};
        @(posedge clk_i);
        #1;
        host_o = {4'h0, ~d};
    endtask : pulse

    // Point the index, then write the byte
    task automatic write_reg(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        // Unused configuration bits always go out as zero
        if (idx == 8'h41) begin
            v = d & 8'he2;
        end
        pulse(4'h8, idx);
        pulse(4'h4, v);
    endtask : write_reg

    // Point the index, sample once the copy has settled, then close the read
    task automatic read_reg(input logic [7:0] idx, output logic [7:0] d);
        pulse(4'h8, idx);
        @(posedge clk_i);
        #1;
        d = rd_data_i;
        pulse(4'h2, 8'h00);
    endtask : read_reg

    // Receive-byte to the alert response address, completed
    task automatic alert_response();
        pulse(4'h1, 8'h19);
    endtask : alert_response

endmodule : tacs_host_model

`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb_top;

    logic                   clk_i;
    logic                   srst_i;
    tacs_pkg::tacs_conv_t   conv_i;      // Measurement engine stand-in
    tacs_pkg::tacs_host_t   host_i;      // Driven by the host model
    tacs_pkg::tacs_result_t result_o;
    tacs_pkg::tacs_result_t res;         // Result captured after a conversion
    logic [7:0]             reg_index_o;
    logic [7:0]             rd_data_o;
    logic                   timeout_en_o;
    logic                   ara_pending_o;
    logic                   standby_o;
    logic                   wide_range_o;
    logic                   soft_reset_o;
    logic                   warn_irq_n_o;
    logic                   warn_irq_n_oe_o;
    logic                   overtemp_out_n_o;
    logic                   overtemp_out_n_oe_o;
    logic [7:0]             rv;          // Read-back byte
    logic                   warn_seen;   // Warn pin just after a conversion
    int                     miscompares;
    int                     comparisons;
    int                     n;
    int                     pulses;

    tacs_regs u_dut (
        .clk_i(clk_i), .srst_i(srst_i), .host_i(host_i), .reg_index_o(reg_index_o),
        .rd_data_o(rd_data_o), .timeout_en_o(timeout_en_o), .ara_pending_o(ara_pending_o),
        .conv_i(conv_i), .standby_o(standby_o), .wide_range_o(wide_range_o),
        .soft_reset_o(soft_reset_o), .result_o(result_o), .warn_irq_n_o(warn_irq_n_o),
        .warn_irq_n_oe_o(warn_irq_n_oe_o), .overtemp_out_n_o(overtemp_out_n_o),
        .overtemp_out_n_oe_o(overtemp_out_n_oe_o)
    );

    tacs_host_model u_host (.clk_i(clk_i), .rd_data_i(rd_data_o), .host_o(host_i));

    // 20 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Compare one byte and count it
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One conversion pulse, limits in the plain encoding
    task automatic conv(input logic [2:0] ch, input logic signed [9:0] t, input logic flt);
        @(posedge clk_i);
        #1;
        conv_i = {1'b1, ch, t, flt, 8'h5a, 8'h0a, 8'h6e};
        @(posedge clk_i);
        #1;
        conv_i.valid = 1'b0;
        conv_i.temp = ~t;
        res = result_o;
        warn_seen = warn_irq_n_oe_o;
    endtask : conv

    // Warn-style layout: b7 ch7, b6 local, b5..0 ch6..1
    function automatic logic [7:0] wbit(input int ch);
        return (ch == 0) ? 8'h40 : (ch == 7) ? 8'h80 : 8'h01 << (ch - 1);
    endfunction : wbit

    // Overtemp layout: b7 local, b6..0 ch7..1
    function automatic logic [7:0] obit(input int ch);
        return (ch == 0) ? 8'h80 : 8'h01 << (ch - 1);
    endfunction : obit

    // Single exit for both the sequence and the watchdog
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    // Watchdog: the sequence needs well under 2000 cycles
    initial begin
        #(8000 * 50);
        miscompares++;
        conclude();
    end

    initial begin
        miscompares = 0;
        comparisons = 0;
        conv_i = '0;
        srst_i = 1'b1;
        repeat (8) @(posedge clk_i);
        #1;
        srst_i = 1'b0;
        // Power-on state
        check("index", reg_index_o, 8'h00);
        check("timeout_en", {7'h0, timeout_en_o}, 8'h01);
        check("pins", {6'h0, warn_irq_n_oe_o, overtemp_out_n_oe_o}, 8'h00);
        check("pin level", {6'h0, warn_irq_n_o, overtemp_out_n_o}, 8'h00);
        for (n = 8'h41; n <= 8'h44; n++) begin
            u_host.read_reg(n[7:0], rv);
            check("reset value", rv, 8'h00);
        end
        check("index", reg_index_o, 8'h44);
        // Standby plus timeout off plus wide range; all set bits kept, reserved ones dropped
        u_host.write_reg(8'h41, 8'hbf);
        u_host.read_reg(8'h41, rv);
        check("config", rv, 8'ha2);
        check("standby", {7'h0, standby_o}, 8'h01);
        check("timeout_en", {7'h0, timeout_en_o}, 8'h00);
        check("wide", {7'h0, wide_range_o}, 8'h01);
        conv(3'd0, 10'sd100, 1'b0);
        check("standby result", {7'h0, res.wr}, 8'h00);
        u_host.write_reg(8'h41, 8'h00);
        // Control outputs follow the stored configuration one cycle later
        @(posedge clk_i);
        #1;
        check("timeout_en", {7'h0, timeout_en_o}, 8'h01);
        // Every channel hot in turn: layout, code, pin, read clears
        for (n = 0; n < 8; n++) begin
            conv(n[2:0], 10'sd100, 1'b0);
            check("result", {res.wr, 4'h0, res.chan}, {1'b1, 4'h0, n[2:0]});
            check("code", res.code, 8'h64);
            check("warn set", {7'h0, warn_seen}, 8'h01);
            u_host.read_reg(8'h44, rv);
            check("high status", rv, wbit(n));
            check("warn read", {7'h0, warn_irq_n_oe_o}, 8'h00);
        end
        u_host.read_reg(8'h44, rv);
        check("high cleared", rv, 8'h00);
        // Alert response drops the pin but not the flag; next conversion sets it again
        conv(3'd5, 10'sd100, 1'b0);
        check("ara pending", {7'h0, ara_pending_o}, 8'h01);
        u_host.alert_response();
        check("warn ara", {7'h0, warn_irq_n_oe_o}, 8'h00);
        conv(3'd5, 10'sd100, 1'b0);
        check("warn again", {7'h0, warn_seen}, 8'h01);
        u_host.read_reg(8'h44, rv);
        check("high kept", rv, 8'h10);
        // Masked local channel still flags
        u_host.write_reg(8'h42, wbit(0));
        conv(3'd0, 10'sd100, 1'b0);
        check("warn masked", {7'h0, warn_seen}, 8'h00);
        u_host.read_reg(8'h44, rv);
        check("masked flag", rv, 8'h40);
        u_host.write_reg(8'h42, 8'h00);
        // Wide encoding adds 64
        u_host.write_reg(8'h41, 8'h02);
        conv(3'd1, -10'sd10, 1'b0);
        check("wide code", res.code, 8'h36);
        conv(3'd1, -10'sd64, 1'b0);
        check("wide floor", res.code, 8'h00);
        u_host.write_reg(8'h41, 8'h00);
        // Low limit
        conv(3'd1, 10'sd5, 1'b0);
        u_host.read_reg(8'h47, rv);
        check("low status", rv, 8'h01);
        // Overtemp set, hysteresis hold, clear
        conv(3'd3, 10'sd120, 1'b0);
        @(posedge clk_i);
        #1;
        check("ot pin", {7'h0, overtemp_out_n_oe_o}, 8'h01);
        u_host.read_reg(8'h45, rv);
        check("ot status", rv, obit(3));
        conv(3'd3, 10'sd107, 1'b0);
        u_host.read_reg(8'h45, rv);
        check("ot hold", rv, obit(3));
        conv(3'd3, 10'sd106, 1'b0);
        u_host.read_reg(8'h45, rv);
        check("ot clear", rv, 8'h00);
        check("ot pin off", {7'h0, overtemp_out_n_oe_o}, 8'h00);
        u_host.write_reg(8'h43, obit(0));
        conv(3'd0, 10'sd120, 1'b0);
        u_host.read_reg(8'h45, rv);
        check("ot masked flag", rv, 8'h80);
        check("ot pin masked", {7'h0, overtemp_out_n_oe_o}, 8'h00);
        // Diode fault: all-ones code, flag, no warn
        u_host.read_reg(8'h44, rv);
        conv(3'd2, 10'sd50, 1'b1);
        check("fault code", res.code, 8'hff);
        check("fault warn", {7'h0, warn_seen}, 8'h00);
        u_host.read_reg(8'h46, rv);
        check("fault status", rv, 8'h02);
        // Soft reset: one pulse, registers back to zero
        u_host.write_reg(8'h41, 8'h40);
        pulses = 0;
        // The pulse is already up when the write returns, so sample first
        repeat (4) begin
            pulses += int'(soft_reset_o === 1'b1);
            @(posedge clk_i);
            #1;
        end
        check("soft pulses", pulses[7:0], 8'h01);
        u_host.read_reg(8'h43, rv);
        check("mask after soft", rv, 8'h00);
        u_host.read_reg(8'h41, rv);
        check("config after soft", rv, 8'h00);
        conclude();
    end

endmodule : tb_top

`default_nettype wire
